/* File: design/ssc_pkg.sv */
package ssc_pkg;
   // Register select: RS=1 with address register value 14.
   localparam logic [3:0] SSC_STATUS_STROBE_AND_CAPTURE_CONTROL_ADDR = 4'hE;
   localparam logic [3:0] SSC_STATUS_ADDR = 4'h0;
   // Field positions inside the control register.
   localparam int SSC_TRG_BIT = 0;
   localparam int SSC_MODE_BIT = 1;
   localparam int SSC_FIN_BIT = 3;
   localparam int SSC_POL_BIT = 4;
   // Values after reset.
   localparam logic SSC_MODE_RST = 1'b0;
   localparam logic SSC_TRG_RST = 1'b1;
   localparam logic SSC_FIN_RST = 1'b0;
   localparam logic SSC_POL_RST = 1'b0;
   // Status FIFO depth.
   localparam int SSC_FIFO_DEPTH = 12;
   localparam logic [3:0] SSC_FIFO_LAST = 4'hB;
   typedef enum logic [1:0] {
      SSC_BUF_IDLE = 2'b00,
      SSC_BUF_RUN = 2'b01,
      SSC_BUF_FINISH = 2'b11
   } ssc_buf_state_t;
endpackage : ssc_pkg

/* File: design/ssc_serial_sampler.sv */
`timescale 1ns/1ns
module ssc_serial_sampler (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial link pins
   input wire logic serial_bit_clock,
   input wire logic serial_disc_data,
   // Control
   input wire logic bit_clock_polarity,
   // Sampled data
   output logic sample_valid,
   output logic sample_bit
);
   import ssc_pkg::*;
   logic [1:0] bck_sync_reg;
   logic [1:0] dat_sync_reg;
   logic bck_prev_reg;
   logic bck_eff;
   logic bck_prev_eff;
   logic sample_edge;
   // Both pins pass two flip-flops; only the second stage is read.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bck_sync_reg <= 2'h0;
         dat_sync_reg <= 2'h0;
         bck_prev_reg <= 1'b0;
      end else begin
         bck_sync_reg <= {bck_sync_reg[0], serial_bit_clock};
         dat_sync_reg <= {dat_sync_reg[0], serial_disc_data};
         bck_prev_reg <= bck_sync_reg[1];
      end
   end
   // Inverting the clock turns the falling-edge sample into a rising-edge one.
   assign bck_eff = bck_sync_reg[1] ^ bit_clock_polarity;
   assign bck_prev_eff = bck_prev_reg ^ bit_clock_polarity;
   // Sample on the falling edge of the (possibly inverted) clock.
   assign sample_edge = bck_prev_eff & ~bck_eff;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sample_valid <= 1'b0;
         sample_bit <= 1'b0;
      end else begin
         sample_valid <= sample_edge;
         if (sample_edge) begin
            sample_bit <= dat_sync_reg[1];
         end
      end
   end
   AST_POL_EDGE: assert property (@(posedge clk) disable iff (!nrst)
      (bit_clock_polarity && $stable(bit_clock_polarity) && !bck_prev_reg
       && bck_sync_reg[1]) |=> sample_valid)
      else $error("Inverted clock rising edge did not sample.");
   AST_NOPOL_EDGE: assert property (@(posedge clk) disable iff (!nrst)
      (!bit_clock_polarity && bck_prev_reg && !bck_sync_reg[1]) |=> sample_valid)
      else $error("Falling edge did not sample.");
endmodule : ssc_serial_sampler

/* File: design/ssc_ctrl.sv */
`timescale 1ns/1ns
module ssc_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Microprocessor register port
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   // Host status read port
   input wire logic host_status_rd,
   output logic [7:0] host_status_data,
   output logic status_available_n,
   // Buffering control
   input wire logic buffer_write_request,
   input wire logic sector_sync,
   output logic buffering_active,
   // Serial disc input
   input wire logic serial_bit_clock,
   input wire logic serial_disc_data,
   output logic serial_sample_valid,
   output logic serial_sample_bit
);
   import ssc_pkg::*;
   logic status_strobe_mode_reg;
   logic status_strobe_trigger_reg;
   logic finish_sector_on_stop_reg;
   logic bit_clock_polarity_reg;
   logic [7:0] fifo_mem [SSC_FIFO_DEPTH];
   logic [3:0] wr_ptr_reg;
   logic [3:0] rd_ptr_reg;
   logic [3:0] count_reg;
   logic stat_n_reg;
   logic ctrl_wr;
   logic stat_wr;
   logic trig_fire;
   logic last_read;
   logic host_rd_ok;
   ssc_buf_state_t buf_reg;
   ssc_buf_state_t buf_next;

   assign ctrl_wr = reg_wr && (reg_addr == SSC_STATUS_STROBE_AND_CAPTURE_CONTROL_ADDR);
   assign stat_wr = reg_wr && (reg_addr == SSC_STATUS_ADDR) && (count_reg != SSC_FIFO_LAST + 4'h1);
   assign host_rd_ok = host_status_rd && !stat_n_reg && (count_reg != 4'h0);
   assign last_read = host_rd_ok && (count_reg == 4'h1);
   // Trigger counts only in mode 1, using the mode already held.
   assign trig_fire = ctrl_wr && status_strobe_mode_reg && !reg_wdata[SSC_TRG_BIT];

   // Control register fields.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_strobe_mode_reg <= SSC_MODE_RST;
         finish_sector_on_stop_reg <= SSC_FIN_RST;
         bit_clock_polarity_reg <= SSC_POL_RST;
      end else if (ctrl_wr) begin
         status_strobe_mode_reg <= reg_wdata[SSC_MODE_BIT];
         finish_sector_on_stop_reg <= reg_wdata[SSC_FIN_BIT];
         bit_clock_polarity_reg <= reg_wdata[SSC_POL_BIT];
      end
   end

   // Trigger bit: 0 marks a pending strobe; the last host read restores idle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_strobe_trigger_reg <= SSC_TRG_RST;
      end else if (trig_fire) begin
         status_strobe_trigger_reg <= 1'b0;
      end else if (last_read) begin
         status_strobe_trigger_reg <= SSC_TRG_RST;
      end
   end

   // Status FIFO storage and pointers.
   always_ff @(posedge clk) begin
      if (stat_wr) begin
         fifo_mem[wr_ptr_reg] <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_reg <= 4'h0;
         rd_ptr_reg <= 4'h0;
         count_reg <= 4'h0;
         host_status_data <= 8'h00;
      end else begin
         if (stat_wr) begin
            wr_ptr_reg <= (wr_ptr_reg == SSC_FIFO_LAST) ? 4'h0 : wr_ptr_reg + 4'h1;
         end
         if (host_rd_ok) begin
            host_status_data <= fifo_mem[rd_ptr_reg];
            rd_ptr_reg <= (rd_ptr_reg == SSC_FIFO_LAST) ? 4'h0 : rd_ptr_reg + 4'h1;
         end
         case ({stat_wr, host_rd_ok})
            2'b10: count_reg <= count_reg + 4'h1;
            2'b01: count_reg <= count_reg - 4'h1;
            default: count_reg <= count_reg;
         endcase
      end
   end

   // Strobe output. A byte write in mode 0 in the same cycle as the last read keeps it low.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stat_n_reg <= 1'b1;
      end else if (stat_wr && !status_strobe_mode_reg) begin
         stat_n_reg <= 1'b0;
      end else if (trig_fire && (count_reg != 4'h0 || stat_wr)) begin
         stat_n_reg <= 1'b0;
      end else if (last_read) begin
         stat_n_reg <= 1'b1;
      end
   end
   assign status_available_n = stat_n_reg;

   // Buffering: with the finish bit the sector in progress completes at next sync.
   always_comb begin
      buf_next = buf_reg;
      case (buf_reg)
         SSC_BUF_IDLE: if (buffer_write_request) buf_next = SSC_BUF_RUN;
         SSC_BUF_RUN: begin
            if (!buffer_write_request) begin
               buf_next = finish_sector_on_stop_reg ? SSC_BUF_FINISH : SSC_BUF_IDLE;
            end
         end
         SSC_BUF_FINISH: begin
            if (sector_sync) buf_next = SSC_BUF_IDLE;
            else if (buffer_write_request) buf_next = SSC_BUF_RUN;
         end
         default: buf_next = SSC_BUF_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         buf_reg <= SSC_BUF_IDLE;
      end else begin
         buf_reg <= buf_next;
      end
   end
   assign buffering_active = (buf_reg != SSC_BUF_IDLE);

   ssc_serial_sampler u_sampler (
      .clk(clk),
      .nrst(nrst),
      .serial_bit_clock(serial_bit_clock),
      .serial_disc_data(serial_disc_data),
      .bit_clock_polarity(bit_clock_polarity_reg),
      .sample_valid(serial_sample_valid),
      .sample_bit(serial_sample_bit)
   );

   sequence s_last_read;
      last_read && !stat_wr && !trig_fire;
   endsequence
   sequence s_strobe_up;
      status_available_n && status_strobe_trigger_reg;
   endsequence

   AST_MODE0_STROBE: assert property (@(posedge clk) disable iff (!nrst)
      (stat_wr && !status_strobe_mode_reg) |=> !status_available_n)
      else $error("Byte write in mode 0 did not assert strobe.");
   AST_MODE1_NOSTROBE: assert property (@(posedge clk) disable iff (!nrst)
      (status_available_n && status_strobe_mode_reg && !trig_fire) |=> status_available_n)
      else $error("Strobe asserted in mode 1 without trigger.");
   AST_RESET_MODE: assert property (@(posedge clk)
      $rose(nrst) |-> !status_strobe_mode_reg && !bit_clock_polarity_reg)
      else $error("Control bits not cleared by reset.");
   AST_TRIG_IGNORED: assert property (@(posedge clk) disable iff (!nrst)
      (ctrl_wr && !status_strobe_mode_reg && status_strobe_trigger_reg && !last_read)
      |=> status_strobe_trigger_reg)
      else $error("Trigger write accepted in mode 0.");
   AST_TRIG_FIRE: assert property (@(posedge clk) disable iff (!nrst)
      (trig_fire && count_reg != 4'h0) |=> !status_available_n && !status_strobe_trigger_reg)
      else $error("Trigger did not assert strobe.");
   AST_TRIG_IDLE: assert property (@(posedge clk) disable iff (!nrst)
      s_last_read |=> s_strobe_up)
      else $error("Last read did not release strobe and trigger.");
   AST_FINISH_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      (buf_reg == SSC_BUF_RUN && !buffer_write_request && finish_sector_on_stop_reg)
      |=> buffering_active)
      else $error("Buffering stopped before sector sync.");
   AST_FINISH_STOP: assert property (@(posedge clk) disable iff (!nrst)
      (buf_reg == SSC_BUF_FINISH && sector_sync) |=> !buffering_active)
      else $error("Buffering did not stop at sector sync.");
   AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!nrst)
      count_reg <= SSC_FIFO_LAST + 4'h1)
      else $error("Status FIFO count above twelve.");
endmodule : ssc_ctrl

/* File: verif/ssc_host_model.sv */
`timescale 1ns/1ns
module ssc_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Bench control
   input wire logic go,
   input wire logic [1:0] gap,
   // Status port
   input wire logic status_available_n,
   input wire logic [7:0] host_status_data,
   output logic host_status_rd,
   // Results
   output logic [4:0] rd_count,
   output logic [23:0] rd_hist
);
   logic [1:0] wait_reg;
   // A nonzero gap spaces the reads out, as a slow host would.
   always @(negedge clk or negedge nrst) begin
      if (!nrst) begin
         host_status_rd <= 1'b0;
         rd_count <= 5'h00;
         rd_hist <= 24'h000000;
         wait_reg <= 2'h0;
      end else begin
         if (host_status_rd) begin
            rd_count <= rd_count + 5'h01;
            rd_hist <= {rd_hist[15:0], host_status_data};
         end
         if (!host_status_rd && go && !status_available_n && wait_reg == 2'h0) begin
            host_status_rd <= 1'b1;
            wait_reg <= gap;
         end else begin
            host_status_rd <= 1'b0;
            if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
         end
      end
   end
endmodule : ssc_host_model

/* File: verif/status_strobe_and_buffer_control_tb.sv */
`timescale 1ns/1ns
module status_strobe_and_buffer_control_tb;
   import ssc_pkg::*;
   logic clk, nrst, reg_wr, host_status_rd, status_available_n, buffer_write_request;
   logic sector_sync, buffering_active, serial_bit_clock, serial_disc_data;
   logic serial_sample_valid, serial_sample_bit, go;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, host_status_data;
   logic [1:0] gap;
   logic [4:0] rd_count, base;
   logic [23:0] rd_hist;
   int num_errors = 0;
   int tests_run = 0;
   ssc_ctrl i_ssc_ctrl (.clk, .nrst, .reg_addr, .reg_wr, .reg_wdata, .host_status_rd,
      .host_status_data, .status_available_n, .buffer_write_request, .sector_sync,
      .buffering_active, .serial_bit_clock, .serial_disc_data, .serial_sample_valid,
      .serial_sample_bit);
   ssc_host_model i_ssc_host_model (.clk, .nrst, .go, .gap, .status_available_n,
      .host_status_data, .host_status_rd, .rd_count, .rd_hist);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task final_report;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   // One idle cycle follows every write, so the strobe is never raised twice at once.
   task wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask : wr
   task rd_host(input logic [4:0] n);
      int i;
      go = 1'b1;
      for (i = 0; i < 200 && rd_count !== base + n; i++) @(negedge clk);
      go = 1'b0;
      chk("host_reads", {3'h0, base + n}, {3'h0, rd_count});
      if (rd_count !== base + n) final_report;
      base = rd_count;
   endtask : rd_host
   task t_reset;
      chk("strobe", 8'h01, {7'h00, status_available_n});
      chk("outs", 8'h00, {5'h00, buffering_active, serial_sample_valid, serial_sample_bit});
      wr(SSC_STATUS_ADDR, 8'h3C);
      chk("strobe", 8'h00, {7'h00, status_available_n});
      rd_host(5'h01);
      chk("data", 8'h3C, rd_hist[7:0]);
      chk("strobe", 8'h01, {7'h00, status_available_n});
   endtask : t_reset
   task t_trigger;
      wr(SSC_STATUS_STROBE_AND_CAPTURE_CONTROL_ADDR, 8'h00);
      wr(SSC_STATUS_STROBE_AND_CAPTURE_CONTROL_ADDR, 8'h03);
      wr(SSC_STATUS_ADDR, 8'hA5);
      chk("strobe", 8'h01, {7'h00, status_available_n});
      wr(SSC_STATUS_ADDR, 8'h5A);
      chk("strobe", 8'h01, {7'h00, status_available_n});
      wr(SSC_STATUS_STROBE_AND_CAPTURE_CONTROL_ADDR, 8'h02);
      chk("strobe", 8'h00, {7'h00, status_available_n});
      rd_host(5'h02);
      chk("data", 8'hA5, rd_hist[15:8]);
      chk("data", 8'h5A, rd_hist[7:0]);
      wr(SSC_STATUS_ADDR, 8'h77);
      chk("strobe", 8'h01, {7'h00, status_available_n});
      wr(SSC_STATUS_STROBE_AND_CAPTURE_CONTROL_ADDR, 8'h02);
      chk("strobe", 8'h00, {7'h00, status_available_n});
      rd_host(5'h01);
   endtask : t_trigger
   // Thirteen writes into twelve places: the last must be dropped.
   task t_fill;
      int i;
      wr(SSC_STATUS_STROBE_AND_CAPTURE_CONTROL_ADDR, 8'h00);
      for (i = 1; i < 14; i++) wr(SSC_STATUS_ADDR, 8'(i));
      chk("strobe", 8'h00, {7'h00, status_available_n});
      gap = 2'h2;
      rd_host(5'h0C);
      chk("data", 8'h0C, rd_hist[7:0]);
      chk("strobe", 8'h01, {7'h00, status_available_n});
      gap = 2'h0;
   endtask : t_fill
   task t_buffer(input logic fin);
      wr(SSC_STATUS_STROBE_AND_CAPTURE_CONTROL_ADDR, {4'h0, fin, 3'h0});
      buffer_write_request = 1'b1;
      repeat (2) @(negedge clk);
      chk("active", 8'h01, {7'h00, buffering_active});
      buffer_write_request = 1'b0;
      repeat (3) @(negedge clk);
      chk("active", {7'h00, fin}, {7'h00, buffering_active});
      sector_sync = 1'b1;
      @(negedge clk);
      sector_sync = 1'b0;
      repeat (2) @(negedge clk);
      chk("active", 8'h00, {7'h00, buffering_active});
   endtask : t_buffer
   task ser(input logic lvl, input logic d, input logic np, input logic b);
      int i;
      logic n;
      logic s;
      n = 1'b0;
      s = 1'b0;
      serial_disc_data = d;
      repeat (3) @(negedge clk);
      serial_bit_clock = lvl;
      for (i = 0; i < 8; i++) begin
         @(negedge clk);
         if (serial_sample_valid === 1'b1) begin
            n = 1'b1;
            s = serial_sample_bit;
         end
      end
      chk("sample", {6'h00, np, np & b}, {6'h00, n, s});
   endtask : ser
   initial begin
      nrst = 1'b0;
      reg_addr = 4'h0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      buffer_write_request = 1'b0;
      sector_sync = 1'b0;
      serial_bit_clock = 1'b0;
      serial_disc_data = 1'b0;
      go = 1'b0;
      gap = 2'h0;
      base = 5'h00;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      t_reset;
      ser(1'b1, 1'b0, 1'b0, 1'b0);
      ser(1'b0, 1'b1, 1'b1, 1'b1);
      t_trigger;
      t_fill;
      t_buffer(1'b0);
      t_buffer(1'b1);
      wr(SSC_STATUS_STROBE_AND_CAPTURE_CONTROL_ADDR, 8'h10);
      ser(1'b1, 1'b1, 1'b1, 1'b1);
      ser(1'b0, 1'b0, 1'b0, 1'b0);
      final_report;
   end
endmodule : status_strobe_and_buffer_control_tb
